// ===== sas_defines.svh
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH
`define SAS_OFS_CTRL      8'hC5
`define SAS_OFS_RESULT    8'hC6
`define SAS_OFS_AUX       8'hA2
`define SAS_CTRL_RESET    8'h00
`define SAS_AUX_RESET     8'h00
`define SAS_BIT_RES1      7
`define SAS_BIT_RES0      6
`define SAS_BIT_EXTEN     5
`define SAS_BIT_DONE      4
`define SAS_BIT_START     3
`define SAS_BIT_8BIT      7
`define SAS_BIT_IDLEACT   6
`define SAS_CLK_PER_MC    12
`define SAS_INIT_MC       2
`define SAS_SAMPLE_MC     8
`define SAS_MC_PER_BIT    4
`define SAS_TOTAL10_MC    50
`define SAS_TOTAL8_MC     24
`endif

// ===== sas_pkg.sv
package sas_pkg;
    typedef enum logic [4:0] {
        SAS_IDLE   = 5'b00001,
        SAS_INIT   = 5'b00010,
        SAS_SAMPLE = 5'b00100,
        SAS_APPROX = 5'b01000,
        SAS_FINISH = 5'b10000
    } sas_state_t;
endpackage

// ===== sas_sequencer.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defines.svh"
module sas_sequencer #(
    parameter int CLK_PER_MC = `SAS_CLK_PER_MC
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // power modes
    input  wire logic       cpu_idle,
    input  wire logic       cpu_power_down,
    // external start and analog side
    input  wire logic       external_start_pin,
    input  wire logic       comparator_above,
    output logic      [9:0] approx_dac_code,
    output logic      [2:0] channel_select,
    output logic            sample_enable,
    output logic            converter_powered,
    output logic            conv_done_irq
);
    import sas_pkg::*;

    // strobe counter is 8 bits; dac code must settle one clock before a tick
    if (CLK_PER_MC < 2 || CLK_PER_MC > 255) begin : g_bad_clk
        $error("CLK_PER_MC out of range");
    end

    // ----------------------------------------
    // machine-cycle strobe
    // ----------------------------------------
    logic [7:0] mc_cnt_reg;
    logic       mc_tick;
    assign mc_tick = (mc_cnt_reg == 8'(CLK_PER_MC - 1));
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            mc_cnt_reg <= 8'h00;
        else if (mc_tick)
            mc_cnt_reg <= 8'h00;
        else
            mc_cnt_reg <= mc_cnt_reg + 8'h01;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [2:0] chan_reg;
    logic       ext_en_reg;
    logic       done_reg;
    logic       status_reg;
    logic       cmd_reg;
    logic [1:0] res_lo_reg;
    logic [7:0] res_hi_reg;
    logic       mode8_reg;
    logic       idle_act_reg;
    sas_state_t state_reg;
    logic [5:0] step_reg;
    logic [3:0] bit_reg;
    logic [9:0] sar_reg;
    logic       pin_last_reg;
    logic       ext_pend_reg;

    logic wr_ctrl;
    logic wr_aux;
    logic halted;
    logic busy;
    logic finish_now;
    assign wr_ctrl = reg_wr && reg_addr == `SAS_OFS_CTRL;
    assign wr_aux  = reg_wr && reg_addr == `SAS_OFS_AUX;
    assign halted  = cpu_power_down || (cpu_idle && !idle_act_reg);
    assign busy    = cmd_reg || status_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode8_reg    <= 1'b0;
            idle_act_reg <= 1'b0;
        end else if (wr_aux) begin
            mode8_reg    <= reg_wdata[`SAS_BIT_8BIT];
            idle_act_reg <= reg_wdata[`SAS_BIT_IDLEACT];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_reg   <= 3'h0;
            ext_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            chan_reg   <= reg_wdata[2:0];
            ext_en_reg <= reg_wdata[`SAS_BIT_EXTEN];
        end
    end

    // ----------------------------------------
    // external edge detect
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_last_reg <= 1'b0;
            ext_pend_reg <= 1'b0;
        end else if (mc_tick) begin
            pin_last_reg <= external_start_pin;
            ext_pend_reg <= external_start_pin && !pin_last_reg;
        end
    end

    // ----------------------------------------
    // command flip-flop
    // ----------------------------------------
    logic sw_start;
    logic ext_start;
    assign sw_start  = wr_ctrl && reg_wdata[`SAS_BIT_START];
    // pending edge lasts one machine cycle, so init follows at the next tick
    assign ext_start = ext_en_reg && ext_pend_reg;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            cmd_reg <= 1'b0;
        else if (halted)
            cmd_reg <= 1'b0;
        else if ((sw_start || ext_start) && !busy && !done_reg)
            cmd_reg <= 1'b1;
        else if (finish_now)
            cmd_reg <= 1'b0;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    logic [5:0] total_mc;
    assign total_mc   = mode8_reg ? 6'(`SAS_TOTAL8_MC)
                                  : 6'(`SAS_TOTAL10_MC);
    assign finish_now = state_reg == SAS_APPROX && mc_tick
                        && step_reg == total_mc - 6'h1;
    logic [3:0] last_bit;
    assign last_bit = mode8_reg ? 4'h2 : 4'h0;
    // eight-bit mode resolves one bit per machine cycle to fit 24 cycles
    logic       bit_due;
    assign bit_due = mode8_reg
                     ? step_reg != 6'(`SAS_INIT_MC + `SAS_SAMPLE_MC + 1)
                     : step_reg[1:0] == 2'h0;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg  <= SAS_IDLE;
            step_reg   <= 6'h00;
            bit_reg    <= 4'h9;
            sar_reg    <= 10'h000;
            status_reg <= 1'b0;
        end else if (halted) begin
            state_reg  <= SAS_IDLE;
            status_reg <= 1'b0;
            step_reg   <= 6'h00;
        end else if (mc_tick) begin
            case (state_reg)
                SAS_IDLE: begin
                    if (cmd_reg) begin
                        state_reg <= SAS_INIT;
                        step_reg  <= 6'h01;
                    end
                end
                SAS_INIT: begin
                    status_reg <= 1'b1;
                    step_reg   <= step_reg + 6'h01;
                    if (step_reg == 6'(`SAS_INIT_MC))
                        state_reg <= SAS_SAMPLE;
                end
                SAS_SAMPLE: begin
                    step_reg <= step_reg + 6'h01;
                    if (step_reg == 6'(`SAS_INIT_MC + `SAS_SAMPLE_MC)) begin
                        state_reg <= SAS_APPROX;
                        sar_reg   <= 10'h200;
                        bit_reg   <= 4'h9;
                    end
                end
                SAS_APPROX: begin
                    step_reg <= step_reg + 6'h01;
                    if (bit_due && bit_reg != 4'hF) begin
                        sar_reg[bit_reg] <= comparator_above;
                        if (bit_reg == last_bit)
                            bit_reg <= 4'hF;
                        else begin
                            sar_reg[bit_reg - 4'h1] <= 1'b1;
                            bit_reg <= bit_reg - 4'h1;
                        end
                    end
                    if (finish_now) begin
                        state_reg  <= SAS_IDLE;
                        status_reg <= 1'b0;
                    end
                end
                default: state_reg <= SAS_IDLE;
            endcase
        end else if (state_reg == SAS_IDLE)
            status_reg <= 1'b0;
    end

    // ----------------------------------------
    // done flag and result
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            done_reg <= 1'b0;
        else if (finish_now && !halted)
            done_reg <= 1'b1;
        else if (wr_ctrl && !reg_wdata[`SAS_BIT_DONE])
            done_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_hi_reg <= 8'h00;
            res_lo_reg <= 2'h0;
        end else if (finish_now && !halted && !done_reg) begin
            res_hi_reg <= sar_reg[9:2];
            res_lo_reg <= mode8_reg ? 2'h0 : sar_reg[1:0];
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            approx_dac_code   <= 10'h000;
            channel_select    <= 3'h0;
            sample_enable     <= 1'b0;
            converter_powered <= 1'b0;
            conv_done_irq     <= 1'b0;
        end else begin
            approx_dac_code   <= sar_reg;
            channel_select    <= chan_reg;
            sample_enable     <= state_reg == SAS_SAMPLE;
            converter_powered <= !halted;
            conv_done_irq     <= done_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `SAS_OFS_CTRL:   reg_rdata <= {res_lo_reg, ext_en_reg,
                                  done_reg, status_reg, chan_reg};
                `SAS_OFS_RESULT: reg_rdata <= res_hi_reg;
                `SAS_OFS_AUX:    reg_rdata <= {mode8_reg, idle_act_reg,
                                  6'h00};
                default:         reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end
endmodule
`default_nettype wire

// ===== sas_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_chk #(
    parameter int CLK_PER_MC = 12
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // converter side
    input wire logic       cpu_power_down,
    input wire logic [9:0] approx_dac_code,
    input wire logic [2:0] channel_select,
    input wire logic       sample_enable,
    input wire logic       converter_powered,
    input wire logic       conv_done_irq
);
    localparam int SAMP1 = 8 * CLK_PER_MC - 1;
    localparam int MC1 = CLK_PER_MC + 1;
    localparam int LO = 13 * CLK_PER_MC;
    localparam int HI = 39 * CLK_PER_MC;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_CHAN: assert property (
        reg_wr && reg_addr == 8'hC5
        |=> ##1 channel_select == $past(reg_wdata[2:0], 2))
        else $error("channel select differs from written value");
    AST_RES_READ: assert property (
        reg_rd && reg_addr == 8'hC6 && conv_done_irq
        |=> reg_rdata == $past(approx_dac_code[9:2]))
        else $error("result byte differs from register contents");
    AST_HOLD: assert property (
        conv_done_irq && $past(conv_done_irq) |-> $stable(approx_dac_code))
        else $error("result changed while done");
    AST_BLOCK: assert property (
        conv_done_irq && $past(conv_done_irq) |-> !sample_enable)
        else $error("sampling while done");
    AST_SAMPLE: assert property (disable iff (sys_rst || cpu_power_down)
        $rose(sample_enable) |-> ##SAMP1 sample_enable ##1 !sample_enable)
        else $error("sampling phase length wrong");
    AST_MSB: assert property (disable iff (sys_rst || cpu_power_down)
        $fell(sample_enable) |-> ##[0:MC1] approx_dac_code == 10'h200)
        else $error("approximation did not start at msb");
    AST_DONE: assert property (disable iff (sys_rst || cpu_power_down)
        $fell(sample_enable) |-> ##[LO:HI] $rose(conv_done_irq))
        else $error("done not raised in time");
    AST_PD_OFF: assert property (
        cpu_power_down |-> ##[1:2] !converter_powered)
        else $error("converter powered in power-down");
    AST_PD_ABORT: assert property (
        $rose(cpu_power_down) |-> ##[1:MC1] !sample_enable)
        else $error("conversion not aborted");
endmodule
bind sas_sequencer sas_sequencer_chk #(.CLK_PER_MC(CLK_PER_MC)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_power_down(cpu_power_down),
    .approx_dac_code(approx_dac_code), .channel_select(channel_select),
    .sample_enable(sample_enable), .converter_powered(converter_powered),
    .conv_done_irq(conv_done_irq));
`default_nettype wire

// ===== sas_analog_src.sv
`timescale 1ns/1ps
`default_nettype none
module sas_analog_src #(
    parameter int CLK_PER_MC = 2
) (
    input  wire logic       sys_clk,
    input  wire logic [2:0] channel_select,
    input  wire logic [9:0] approx_dac_code,
    input  wire logic       start_req,
    output logic            comparator_above,
    output logic            external_start_pin
);
    logic [9:0] ain;
    always_comb begin
        case (channel_select)
            3'h5: ain = 10'h2A8;
            3'h2: ain = 10'h0F2;
            default: ain = 10'h155;
        endcase
    end
    assign comparator_above = ain > approx_dac_code;
    initial external_start_pin = 1'b0;
    // low two machine cycles (2 * CLK_PER_MC clocks), high four, then back low
    always @(posedge start_req) begin
        external_start_pin <= 1'b0;
        repeat (2 * CLK_PER_MC) @(posedge sys_clk);
        external_start_pin <= 1'b1;
        repeat (4 * CLK_PER_MC) @(posedge sys_clk);
        external_start_pin <= 1'b0;
    end
endmodule
`default_nettype wire

// ===== tb_sas_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sas_sequencer;
    logic       sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic       cpu_idle = 0, cpu_power_down = 0, start_req = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [9:0] approx_dac_code;
    logic [2:0] channel_select;
    logic       pin, cmp_above, sample_enable, powered, conv_done_irq;
    int         errors = 0, cmp_count = 0, cyc = 0, n;
    always #2 sys_clk = ~sys_clk;
    sas_sequencer #(.CLK_PER_MC(2)) dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_idle(cpu_idle), .cpu_power_down(cpu_power_down),
        .external_start_pin(pin), .comparator_above(cmp_above),
        .approx_dac_code(approx_dac_code), .channel_select(channel_select),
        .sample_enable(sample_enable), .converter_powered(powered),
        .conv_done_irq(conv_done_irq));
    sas_analog_src #(.CLK_PER_MC(2)) u_src (.sys_clk(sys_clk),
        .channel_select(channel_select), .approx_dac_code(approx_dac_code),
        .start_req(start_req), .comparator_above(cmp_above),
        .external_start_pin(pin));
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, m, e, input string s);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(s, e, reg_rdata & m);
    endtask
    task wait_on(input bit sel);
        n = 0;
        while ((sel ? sample_enable : conv_done_irq) !== 1'b1
               && n < 400) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask
    task pulse;
        @(posedge sys_clk);
        start_req <= 1'b1;
        @(posedge sys_clk);
        start_req <= 1'b0;
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test;
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(8'hC5, 8'hFF, 8'h00, "ctrl");
        rd(8'hA2, 8'hFF, 8'h00, "aux");
        rd(8'h00, 8'hFF, 8'h00, "unmapped");
        $display("test reset done");
        wr(8'hC5, 8'h0D);
        wr(8'hC5, 8'h0D);
        wait_on(1'b0);
        chk("time10", 8'h01, {7'h0, n >= 97 && n <= 103});
        @(posedge sys_clk);
        cpu_idle <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cpu_idle <= 1'b0;
        wr(8'hC5, 8'h1D);
        repeat (20) @(posedge sys_clk);
        rd(8'hC6, 8'hFF, 8'hA9, "res10");
        rd(8'hC5, 8'hFF, 8'hD5, "ctrl10");
        wr(8'hC5, 8'h05);
        rd(8'hC5, 8'h3F, 8'h05, "clear");
        wr(8'hC5, 8'h15);
        rd(8'hC5, 8'h3F, 8'h05, "noset");
        $display("test ten_bit done");
        wr(8'hA2, 8'h80);
        wr(8'hC5, 8'h02);
        pulse;
        repeat (30) @(posedge sys_clk);
        #1 chk("noext", 8'h00, {7'h0, conv_done_irq});
        wr(8'hC5, 8'h22);
        pulse;
        @(posedge pin);
        wait_on(1'b0);
        chk("time8", 8'h01, {7'h0, n >= 48 && n <= 56});
        rd(8'hC6, 8'hFF, 8'h3C, "res8");
        rd(8'hC5, 8'hFF, 8'h32, "ctrl8");
        $display("test eight_bit done");
        wr(8'hC5, 8'h01);
        wr(8'hA2, 8'h00);
        wr(8'hC5, 8'h09);
        wait_on(1'b1);
        @(posedge sys_clk);
        cpu_power_down <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cpu_power_down <= 1'b0;
        repeat (120) @(posedge sys_clk);
        #1 chk("abort", 8'h00, {7'h0, conv_done_irq});
        rd(8'hC5, 8'h18, 8'h00, "abort_st");
        $display("test abort done");
        wr(8'hA2, 8'h40);
        wr(8'hC5, 8'h09);
        cpu_idle <= 1'b1;
        wait_on(1'b0);
        cpu_idle <= 1'b0;
        chk("idle_run", 8'h01, {7'h0, conv_done_irq});
        rd(8'hC6, 8'hFF, 8'h55, "res_idle");
        $display("test idle_active done");
        stop_test;
    end
endmodule
`default_nettype wire
